//--- design/dhi_device.sv
// Summary of operation
// - Straps pick I2C, serial or parallel link
// - Hard reset low returns state to defaults
// - Host keeps hard reset high normally
// - Bus activity ignored while chip select high
// - Parallel data/command bit routes each byte
// - Serial data/command bit routes shifted byte
// - I2C mode uses data/command as address LSB
// - Enable-strobe cycle starts on enable high
// - Host sets direction high read, low write
// - Read strobe low starts a data read
// - Write strobe low starts a data write
// - Host grounds strobes in serial/I2C modes
// - Serial data on bits 2,1; clock bit 0
// - I2C data on bits 2,1; clock bit 0
// - Parallel bus is bidirectional
// - Host ties unused bus lines low
// - Device outputs frame sync for tearing
`include "dhi_map.svh"
module dhi_device
   import dhi_pkg::*;
#(
   parameter logic [15:0] FRAME_CYC = `DHI_FRAME_CYC
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   dhi_link_if.device link,
   output logic       rx_valid,
   output logic [7:0] rx_byte,
   output logic       rx_is_data,
   input  wire logic  [7:0] rd_byte
);
   typedef struct packed {
      logic [1:0]  mode;
      logic [2:0]  sync;
      logic [7:0]  shift;
      logic [2:0]  bit_cnt;
      logic        busy;
      logic        strobe_prev;
      logic        sclk_prev;
      logic        rx_valid;
      logic [7:0]  rx_byte;
      logic        rx_is_data;
      logic        drive;
      logic [7:0]  bus_o;
      logic [15:0] frame_cnt;
      logic        frame;
      logic        i2c_ack;
   } dhi_dev_st_type;
   dhi_dev_st_type st_reg;
   dhi_dev_st_type st_next;
   dhi_mode_type   mode;
   logic           par_strobe;
   logic           rd_req;

   assign mode = dhi_mode_type'(st_reg.mode);

   // Strobe active level per parallel style
   always_comb begin
      par_strobe = 1'b0;
      rd_req     = 1'b0;
      if (mode == DHI_PAR_E) begin
         par_strobe = link.enable_rd_n;
         rd_req     = link.dir_wr_n;
      end else if (mode == DHI_PAR_RW) begin
         par_strobe = !link.enable_rd_n || !link.dir_wr_n;
         rd_req     = !link.enable_rd_n;
      end
   end

   always_comb begin
      st_next          = st_reg;
      st_next.rx_valid = 1'b0;
      st_next.mode     = {link.protocol_strap_a, link.protocol_strap_b};
      st_next.strobe_prev = par_strobe;
      st_next.sclk_prev   = link.host_bus[0];
      // Free-running frame counter
      if (st_reg.frame_cnt == FRAME_CYC - 16'h0001) begin
         st_next.frame_cnt = '0;
         st_next.frame     = !st_reg.frame;
      end else begin
         st_next.frame_cnt = st_reg.frame_cnt + 16'h0001;
      end
      if (link.cs_n) begin
         st_next.drive   = 1'b0;
         st_next.bit_cnt = '0;
         st_next.i2c_ack = 1'b0;
         st_next.busy    = 1'b0;
      end else begin
         unique case (mode)
            DHI_PAR_E, DHI_PAR_RW: begin
               if (par_strobe && !st_reg.strobe_prev) begin
                  if (rd_req) begin
                     st_next.drive = 1'b1;
                     st_next.bus_o = rd_byte;
                  end else begin
                     st_next.rx_valid   = 1'b1;
                     st_next.rx_byte    = link.host_bus;
                     st_next.rx_is_data = link.data_cmd;
                  end
               end else if (!par_strobe) begin
                  st_next.drive = 1'b0;
               end
            end
            DHI_SPI4: begin
               if (link.host_bus[0] && !st_reg.sclk_prev) begin
                  st_next.shift   = {st_reg.shift[6:0], link.host_bus[1]};
                  st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                  if (st_reg.bit_cnt == 3'h7) begin
                     st_next.rx_valid   = 1'b1;
                     st_next.rx_byte    = {st_reg.shift[6:0], link.host_bus[1]};
                     st_next.rx_is_data = link.data_cmd;
                  end
               end
            end
            DHI_I2C: begin
               // Address byte then data bytes; ack low on bit 2
               if (link.host_bus[0] && !st_reg.sclk_prev && !st_reg.i2c_ack) begin
                  st_next.shift   = {st_reg.shift[6:0], link.host_bus[1]};
                  st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                  if (st_reg.bit_cnt == 3'h7) begin
                     st_next.i2c_ack = 1'b1;
                     if (!st_reg.busy) begin
                        st_next.busy = ({st_reg.shift[6:0], link.host_bus[1]} ==
                                        {`DHI_I2C_ADDR_HI, link.data_cmd, 1'b0});
                        st_next.drive = st_next.busy;
                     end else begin
                        st_next.rx_valid   = 1'b1;
                        st_next.rx_byte    = {st_reg.shift[6:0], link.host_bus[1]};
                        st_next.rx_is_data = 1'b1;
                        st_next.drive      = 1'b1;
                     end
                     st_next.bus_o = 8'h00;
                  end
               end else if (!link.host_bus[0] && st_reg.sclk_prev && st_reg.i2c_ack) begin
                  st_next.i2c_ack = 1'b0;
                  st_next.drive   = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         st_reg <= '0;
      else if (!link.hard_reset_in_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign link.host_bus_dev_o    = st_reg.bus_o;
   assign link.host_bus_dev_oe_n = (mode == DHI_I2C) ? {5'h1F, !st_reg.drive, 2'b11}
                                                     : {8{!st_reg.drive}};
   assign link.frame_sync_out    = st_reg.frame;
   assign rx_valid               = st_reg.rx_valid;
   assign rx_byte                = st_reg.rx_byte;
   assign rx_is_data             = st_reg.rx_is_data;
endmodule

//--- design/dhi_fifo.sv
module dhi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } dhi_fifo_st_type;
   dhi_fifo_st_type st_reg;
   dhi_fifo_st_type st_next;
   logic            push;
   logic            pop;

   assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
      end
      if (pop)
         st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
      st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
endmodule

//--- design/dhi_host.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`include "dhi_map.svh"
module dhi_host
   import dhi_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   dhi_link_if.host         link
);
   typedef struct packed {
      logic [3:0]    ctrl;
      logic [1:0]    mode;
      logic [7:0]    rx;
      logic [3:0]    cnt;
      logic [3:0]    bit_n;
      logic          rd;
      logic          dc;
      logic [7:0]    data;
      logic [2:0]    state;
      logic          cs_n;
      logic          en_rd_n;
      logic          dir_wr_n;
      logic          oe;
      logic [7:0]    bus_o;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } dhi_host_st_type;
   dhi_host_st_type st_reg;
   dhi_host_st_type st_next;
   logic            f_in_valid;
   logic            f_in_ready;
   logic            f_out_valid;
   logic            f_out_ready;
   logic [8:0]      f_out_data;
   logic            wr_hit;
   dhi_mode_type    mode;
   dhi_state_type   state;

   assign mode   = dhi_mode_type'(st_reg.mode);
   assign state  = dhi_state_type'(st_reg.state);
   assign wr_hit = psel && penable && pwrite && paddr == `DHI_APB_TXDATA;
   // Write stalls while FIFO is full
   assign f_in_valid  = wr_hit && !st_reg.pready;
   assign f_out_ready = (state == DHI_IDLE);

   dhi_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   ({pwdata[8], pwdata[7:0]}),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   always_comb begin
      st_next         = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      if (psel && penable && !st_reg.pready) begin
         st_next.pready = !wr_hit || f_in_ready;
         unique case (paddr)
            `DHI_APB_CTRL: begin
               if (pwrite)
                  st_next.ctrl = pwdata[3:0];
               st_next.prdata = {28'h0, st_reg.ctrl};
            end
            `DHI_APB_STATUS: st_next.prdata = {27'h0, st_reg.mode, f_in_ready,
                                               f_out_valid, state != DHI_IDLE};
            `DHI_APB_TXDATA: st_next.prdata = '0;
            `DHI_APB_RXDATA: st_next.prdata = {24'h0, st_reg.rx};
            default: begin
               st_next.prdata  = '0;
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      unique case (state)
         DHI_IDLE: begin
            st_next.oe = 1'b0;
            if (f_out_valid) begin
               st_next.dc    = f_out_data[8];
               st_next.data  = f_out_data[7:0];
               st_next.rd    = 1'b0;
               st_next.cs_n  = 1'b0;
               st_next.cnt   = '0;
               st_next.bit_n = '0;
               st_next.state = 3'(DHI_SETUP);
            end
         end
         DHI_SETUP: begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `DHI_STRB_CYC) begin
               st_next.cnt = '0;
               if (mode == DHI_SPI4 || mode == DHI_I2C) begin
                  st_next.state = 3'(DHI_SHIFT);
               end else begin
                  st_next.oe    = 1'b1;
                  st_next.bus_o = st_reg.data;
                  if (mode == DHI_PAR_E) begin
                     st_next.dir_wr_n = 1'b0;
                     st_next.en_rd_n  = 1'b1;
                  end else begin
                     st_next.dir_wr_n = 1'b0;
                  end
                  st_next.state = 3'(DHI_STROBE);
               end
            end
         end
         DHI_STROBE: begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `DHI_STRB_CYC) begin
               st_next.en_rd_n  = (mode == DHI_PAR_RW);
               st_next.dir_wr_n = (mode == DHI_PAR_RW);
               st_next.state    = 3'(DHI_DONE);
            end
         end
         DHI_SHIFT: begin
            // Serial clock on bit 0, data on bits 2,1
            st_next.oe  = 1'b1;
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `DHI_SCLK_HALF) begin
               st_next.bus_o = {5'h00, st_reg.data[7], st_reg.data[7], 1'b0};
            end else if (st_reg.cnt == (`DHI_SCLK_HALF << 1)) begin
               st_next.cnt   = '0;
               st_next.bus_o[0] = 1'b1;
               st_next.data  = {st_reg.data[6:0], 1'b0};
               st_next.bit_n = st_reg.bit_n + 4'h1;
               if (st_reg.bit_n == 4'h7)
                  st_next.state = 3'(DHI_DONE);
            end
         end
         DHI_DONE: begin
            st_next.oe    = 1'b0;
            st_next.cs_n  = 1'b1;
            st_next.bus_o = '0;
            st_next.state = 3'(DHI_IDLE);
         end
         default: st_next.state = 3'(DHI_IDLE);
      endcase
      if (state == DHI_IDLE)
         st_next.mode = st_reg.ctrl[`DHI_CTRL_GO_BIT] ? st_reg.mode : st_reg.ctrl[1:0];
      if (state == DHI_IDLE && !st_reg.ctrl[`DHI_CTRL_GO_BIT])
         st_next.en_rd_n = (mode == DHI_PAR_RW);
      if (state == DHI_IDLE && !st_reg.ctrl[`DHI_CTRL_GO_BIT])
         st_next.dir_wr_n = (mode == DHI_PAR_RW);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg       <= '0;
         st_reg.ctrl  <= `DHI_CTRL_RESET;
         st_reg.cs_n  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata                  = st_reg.prdata;
   assign pready                  = st_reg.pready;
   assign pslverr                 = st_reg.pslverr;
   assign link.protocol_strap_a   = st_reg.mode[1];
   assign link.protocol_strap_b   = st_reg.mode[0];
   assign link.hard_reset_in_n    = st_reg.ctrl[`DHI_CTRL_RST_BIT];
   assign link.cs_n               = st_reg.cs_n;
   assign link.data_cmd           = st_reg.dc;
   // Strobes grounded in serial modes
   assign link.enable_rd_n        = st_reg.en_rd_n;
   assign link.dir_wr_n           = st_reg.dir_wr_n;
   assign link.host_bus_host_o    = st_reg.bus_o;
   assign link.host_bus_host_oe_n = {8{!st_reg.oe}};
endmodule

//--- design/dhi_link_if.sv
interface dhi_link_if;
   logic       protocol_strap_a;
   logic       protocol_strap_b;
   logic       hard_reset_in_n;
   logic       cs_n;
   logic       data_cmd;
   logic       enable_rd_n;
   logic       dir_wr_n;
   logic [7:0] host_bus_host_o;
   logic [7:0] host_bus_host_oe_n;
   logic [7:0] host_bus_dev_o;
   logic [7:0] host_bus_dev_oe_n;
   logic       frame_sync_out;
   logic [7:0] host_bus;

   // Wire level: driven value, else pulled low
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!host_bus_dev_oe_n[i])
            host_bus[i] = host_bus_dev_o[i];
         else if (!host_bus_host_oe_n[i])
            host_bus[i] = host_bus_host_o[i];
         else
            host_bus[i] = 1'b0;
      end
   end

   modport device (
      input  protocol_strap_a, protocol_strap_b, hard_reset_in_n, cs_n, data_cmd,
      input  enable_rd_n, dir_wr_n, host_bus,
      output host_bus_dev_o, host_bus_dev_oe_n, frame_sync_out
   );
   modport host (
      output protocol_strap_a, protocol_strap_b, hard_reset_in_n, cs_n, data_cmd,
      output enable_rd_n, dir_wr_n, host_bus_host_o, host_bus_host_oe_n,
      input  host_bus, frame_sync_out
   );
endinterface

//--- design/dhi_map.svh
`ifndef DHI_MAP_SVH
`define DHI_MAP_SVH
`define DHI_APB_CTRL      12'h000
`define DHI_APB_STATUS    12'h004
`define DHI_APB_TXDATA    12'h008
`define DHI_APB_RXDATA    12'h00C
`define DHI_CTRL_RD_BIT   0
`define DHI_CTRL_DC_BIT   1
`define DHI_CTRL_RST_BIT  2
`define DHI_CTRL_GO_BIT   3
`define DHI_CTRL_RESET    4'h4
`define DHI_STRB_CYC      4'h4
`define DHI_SCLK_HALF     4'h2
`define DHI_FRAME_CYC     16'h0400
`define DHI_I2C_ADDR_HI   6'h1E
`endif

//--- design/dhi_pkg.sv
package dhi_pkg;
   typedef enum logic [1:0] {
      DHI_SPI4  = 2'b00,
      DHI_PAR_E = 2'b01,
      DHI_I2C   = 2'b10,
      DHI_PAR_RW = 2'b11
   } dhi_mode_type;

   typedef enum logic [2:0] {
      DHI_IDLE,
      DHI_SETUP,
      DHI_STROBE,
      DHI_SHIFT,
      DHI_DONE
   } dhi_state_type;
endpackage

//--- tb/dhi_link_assertions.sv
module dhi_link_assertions #(
   parameter int FRAME_CYC = 16
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       protocol_strap_a,
   input wire logic       protocol_strap_b,
   input wire logic       hard_reset_in_n,
   input wire logic       cs_n,
   input wire logic       enable_rd_n,
   input wire logic       dir_wr_n,
   input wire logic [7:0] host_bus_host_oe_n,
   input wire logic [7:0] host_bus_dev_oe_n,
   input wire logic       frame_sync_out,
   input wire logic [7:0] host_bus
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic        par_e;
   logic        par_rw;
   logic        spi;
   logic [15:0] fs_cnt_reg;
   logic        fs_prev_reg;

   assign par_e  = !protocol_strap_a && protocol_strap_b;
   assign par_rw = protocol_strap_a && protocol_strap_b;
   assign spi    = !protocol_strap_a && !protocol_strap_b;

   // Cycles since the last frame sync edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_cnt_reg  <= 16'h0000;
         fs_prev_reg <= 1'b0;
      end else begin
         fs_prev_reg <= frame_sync_out;
         if (!hard_reset_in_n || frame_sync_out != fs_prev_reg)
            fs_cnt_reg <= 16'h0000;
         else
            fs_cnt_reg <= fs_cnt_reg + 16'h0001;
      end
   end

   a_straps_framed: assert property (!cs_n ##1 !cs_n |->
      $stable({protocol_strap_a, protocol_strap_b})) else $error("straps moved in frame");
   a_strobes_grounded: assert property (!protocol_strap_b ##1 !protocol_strap_b
      |-> !enable_rd_n && !dir_wr_n) else $error("strobes not grounded");
   a_enable_framed: assert property (par_e && $stable(protocol_strap_a)
      && $rose(enable_rd_n) |-> !cs_n) else $error("enable outside select");
   a_write_framed: assert property (par_rw && $stable(protocol_strap_a)
      && $fell(dir_wr_n) |-> !cs_n) else $error("write strobe outside select");
   a_sclk_framed: assert property (spi && $stable(protocol_strap_b)
      && $rose(host_bus[0]) |-> !cs_n) else $error("serial clock outside select");
   a_no_contention: assert property (
      (host_bus_dev_oe_n | host_bus_host_oe_n) == 8'hFF) else $error("bus contention");
   a_dev_drive_sel: assert property (host_bus_dev_oe_n != 8'hFF |->
      !cs_n || $past(!cs_n)) else $error("device drives while deselected");
   a_hreset_quiet: assert property (!hard_reset_in_n ##1 !hard_reset_in_n
      |-> host_bus_dev_oe_n == 8'hFF) else $error("device active in hard reset");
   a_spi_unused_low: assert property (spi && !cs_n |->
      host_bus[7:3] == 5'h00) else $error("unused lines not low");
   a_fsync_gap: assert property (disable iff (!presetn || !hard_reset_in_n)
      frame_sync_out != fs_prev_reg |-> fs_cnt_reg >= FRAME_CYC - 2)
      else $error("frame sync early");
   a_fsync_bound: assert property (disable iff (!presetn || !hard_reset_in_n)
      fs_cnt_reg <= FRAME_CYC) else $error("frame sync late");

   c_spi_frame: cover property (spi && $fell(cs_n));
   c_par_e_frame: cover property (par_e && $fell(cs_n));
   c_par_rw_frame: cover property (par_rw && $fell(cs_n));
endmodule

//--- tb/display_host_interface_select_tb.sv
`include "dhi_map.svh"
module display_host_interface_select_tb;
   import dhi_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   logic        rx_is_data;
   logic        rx2_valid;
   logic [7:0]  rx2_byte;
   logic        rx2_is_data;
   logic [8:0]  rxq[$];
   logic [8:0]  rx2q[$];
   logic [31:0] rd;
   logic        err;
   logic [7:0]  seen2;
   logic [7:0]  rd2_byte;
   int          bad_count;
   int          compares;

   dhi_link_if link ();
   dhi_link_if link2 ();

   dhi_host u_dhi_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link.host));
   dhi_device #(.FRAME_CYC(16'h0010)) u_dhi_device (.pclk(pclk), .presetn(presetn),
      .link(link.device), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_is_data(rx_is_data), .rd_byte(8'h5A));
   // Second device driven straight by the bench
   dhi_device #(.FRAME_CYC(16'h0010)) u_dhi_device2 (.pclk(pclk), .presetn(presetn),
      .link(link2.device), .rx_valid(rx2_valid), .rx_byte(rx2_byte),
      .rx_is_data(rx2_is_data), .rd_byte(rd2_byte));
   dhi_link_assertions #(.FRAME_CYC(16)) u_dhi_link_assertions (.pclk(pclk),
      .presetn(presetn), .protocol_strap_a(link.protocol_strap_a),
      .protocol_strap_b(link.protocol_strap_b), .hard_reset_in_n(link.hard_reset_in_n),
      .cs_n(link.cs_n), .enable_rd_n(link.enable_rd_n), .dir_wr_n(link.dir_wr_n),
      .host_bus_host_oe_n(link.host_bus_host_oe_n), .host_bus_dev_oe_n(link.host_bus_dev_oe_n),
      .frame_sync_out(link.frame_sync_out), .host_bus(link.host_bus));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (rx_valid === 1'b1)
         rxq.push_back({rx_is_data, rx_byte});
      if (rx2_valid === 1'b1)
         rx2q.push_back({rx2_is_data, rx2_byte});
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 400)
         check("apb answer", 0, 1);
   endtask

   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (rxq.size() < n && k < 3000) begin
         @(negedge pclk);
         k++;
      end
   endtask

   task automatic test_reset();
      apb(1'b0, `DHI_APB_CTRL, 32'h0);
      check("ctrl reset", rd, {28'h0, `DHI_CTRL_RESET});
      check("hard reset level", link.hard_reset_in_n, 1'b1);
      check("cs idle", link.cs_n, 1'b1);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped refused", err, 1'b1);
   endtask

   task automatic test_modes();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `DHI_APB_CTRL, {30'h1, i[1:0]});
         repeat (2) @(negedge pclk);
         check("strap a", link.protocol_strap_a, i[1]);
         check("strap b", link.protocol_strap_b, i[0]);
         if (i[0] == 1'b0)
            check("strobes", {link.enable_rd_n, link.dir_wr_n}, 2'b00);
      end
   endtask

   // Data byte then command byte, back to back
   task automatic test_send(input logic [1:0] m);
      int base;
      apb(1'b1, `DHI_APB_CTRL, {30'h1, m});
      base = rxq.size();
      apb(1'b1, `DHI_APB_TXDATA, 32'h1A5);
      apb(1'b1, `DHI_APB_TXDATA, 32'h03C);
      wait_rx(base + 2);
      check("rx data", {23'h0, rxq[base]}, 32'h1A5);
      check("rx cmd", {23'h0, rxq[base + 1]}, 32'h03C);
   endtask

   // Overfills the queue; writes must stall, not drop
   task automatic test_fifo();
      int base;
      apb(1'b1, `DHI_APB_CTRL, 32'h4);
      base = rxq.size();
      for (int i = 0; i < 6; i++)
         apb(1'b1, `DHI_APB_TXDATA, 32'h100 | i);
      wait_rx(base + 6);
      for (int i = 0; i < 6; i++)
         check("fifo order", {23'h0, rxq[base + i]}, 32'h100 | i);
   endtask

   task automatic test_hard_reset();
      logic v;
      @(negedge pclk);
      v = link.frame_sync_out;
      repeat (16) @(negedge pclk);
      check("fsync toggle", link.frame_sync_out, !v);
      apb(1'b1, `DHI_APB_CTRL, 32'h0);
      repeat (40) @(negedge pclk);
      check("hard reset low", link.hard_reset_in_n, 1'b0);
      check("fsync held", link.frame_sync_out, 1'b0);
      apb(1'b1, `DHI_APB_CTRL, 32'h4);
      check("hard reset high", link.hard_reset_in_n, 1'b1);
   endtask

   task automatic pulse2(input logic wr, input logic cs);
      @(posedge pclk);
      link2.cs_n <= cs;
      @(posedge pclk);
      link2.dir_wr_n    <= !wr;
      link2.enable_rd_n <= wr;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      seen2 = link2.host_bus;
      @(posedge pclk);
      link2.dir_wr_n    <= 1'b1;
      link2.enable_rd_n <= 1'b1;
      repeat (6) @(posedge pclk);
      link2.cs_n <= 1'b1;
   endtask

   task automatic test_far_cs();
      int base;
      base = rx2q.size();
      pulse2(1'b1, 1'b1);
      check("deselected write", rx2q.size(), base);
      pulse2(1'b1, 1'b0);
      check("selected write", {23'h0, rx2q[base]}, 32'h1A5);
      @(posedge pclk);
      link2.host_bus_host_oe_n <= 8'hFF;
      pulse2(1'b0, 1'b0);
      check("read drive", seen2, 8'h96);
   endtask

   task automatic i2c_byte2(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge pclk);
         link2.host_bus_host_o <= {5'h00, b[i], b[i], 1'b0};
         repeat (2) @(posedge pclk);
         link2.host_bus_host_o[0] <= 1'b1;
      end
      repeat (2) @(negedge pclk);
   endtask

   // Wrong address, right address, then one data byte
   task automatic test_i2c();
      int base;
      base = rx2q.size();
      @(posedge pclk);
      link2.protocol_strap_b   <= 1'b0;
      link2.cs_n               <= 1'b0;
      link2.host_bus_host_o    <= 8'h00;
      link2.host_bus_host_oe_n <= 8'h00;
      i2c_byte2({`DHI_I2C_ADDR_HI, 1'b0, 1'b0});
      check("i2c other address", link2.host_bus_dev_oe_n, 8'hFF);
      i2c_byte2({`DHI_I2C_ADDR_HI, 1'b1, 1'b0});
      check("i2c address ack", link2.host_bus_dev_oe_n, 8'hFB);
      i2c_byte2(8'h3C);
      @(negedge pclk);
      check("i2c data", {23'h0, rx2q[base]}, 32'h13C);
      @(posedge pclk);
      link2.cs_n <= 1'b1;
   endtask

   initial begin
      bad_count = 0;
      compares  = 0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0;
      rd2_byte  = 8'h96;
      link2.protocol_strap_a   = 1'b1;
      link2.protocol_strap_b   = 1'b1;
      link2.hard_reset_in_n    = 1'b1;
      link2.cs_n               = 1'b1;
      link2.data_cmd           = 1'b1;
      link2.enable_rd_n        = 1'b1;
      link2.dir_wr_n           = 1'b1;
      link2.host_bus_host_o    = 8'hA5;
      link2.host_bus_host_oe_n = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_modes();
      test_send(2'b00);
      test_send(2'b01);
      test_send(2'b11);
      test_fifo();
      test_hard_reset();
      test_far_cs();
      test_i2c();
      print_verdict();
   end

   initial begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      print_verdict();
   end
endmodule
